// ==== core/vmode_params.svh ====
// Notes on behaviour
// [RULE_01] Any write of the page directory base register invalidates every lookaside entry.
// [RULE_02] Software flushes the lookaside buffer after changing page entries, notably present bits.
// [RULE_03] A task switch loads the page directory base register from the task segment.
// [RULE_04] Legacy mode linear address is segment value shifted left four plus offset.
// [RULE_05] Legacy or real mode offsets beyond 64K bytes raise fault 13.
// [RULE_06] The 20-bit legacy linear space pages through the lookaside buffer, 256 pages.
// [RULE_07] Legacy mode code always runs at privilege level 3 with full checks.
// [RULE_08] Table loads, machine word, task flag, halt, special moves fault 13 above level 0.
// [RULE_09] Task, local table, rights, limit and verify ops fault 6 outside protected mode.
// [RULE_10] Protected mode port, block port and interrupt mask ops obey the I/O level.
// [RULE_11] Legacy mode soft interrupt, mask, flags push/pop and trap return obey I/O level.
// [RULE_12] Breakpoint 0CCH, overflow trap and bound check never obey the I/O level.
// [RULE_13] Legacy mode port I/O skips the I/O level, checks the task segment bitmap.
// [RULE_14] Bitmap pointer is the 16-bit word at task segment offset 66H.
// [RULE_15] Software keeps the bitmap pointer at or below DFFFH.
// [RULE_16] One bitmap bit per byte port; 0 permits, 1 raises fault 13.
// [RULE_17] Wide port accesses need every covered bit 0, otherwise fault 13.
// [RULE_18] Bitmap bytes beyond the task segment limit count as not permitted.
// [RULE_19] Software puts an FFH terminator byte after the bitmap, inside the limit.
// [RULE_20] Port p bit sits at byte base plus p>>3, bit p mod 8, crossing bytes.
`ifndef VMODE_PARAMS_SVH
`define VMODE_PARAMS_SVH

`define CTRL_OFF 8'h00
`define PDBR_OFF 8'h04
`define TSS_BASE_OFF 8'h08
`define TSS_LIMIT_OFF 8'h0c
`define TASK_SWITCH_OFF 8'h10
`define SEG_OFF 8'h14
`define EA_OFF 8'h18
`define LIN_OFF 8'h1c
`define PHYS_OFF 8'h20
`define XLATE_STAT_OFF 8'h24
`define TLB_VPN_OFF 8'h28
`define TLB_PFN_OFF 8'h2c
`define CHECK_OFF 8'h30
`define CHECK_STAT_OFF 8'h34
`define BITMAP_PTR_OFF 8'h38

`define CTRL_PROT_BIT 0
`define CTRL_VMODE_BIT 1
`define CTRL_PAGING_BIT 2
`define CTRL_CPL_LSB 3
`define CTRL_IO_PRIVILEGE_LEVEL_LSB 5
`define CTRL_RESET 32'h0000_0000
`define TSS_LIMIT_RESET 32'h0000_0067
`define CHK_OP_LSB 0
`define CHK_SIZE_LSB 5
`define CHK_PORT_LSB 16

`define TSS_PDBR_BYTE 32'h0000_001c
`define TSS_BMP_PTR_BYTE 32'h0000_0066
`define SEG_SHIFT 4
`define EA_MAX 32'h0000_ffff
`define VEC_GP 8'h0d
`define VEC_UD 8'h06
`define TS_BYTES 3'd6
`define PDBR_BYTES 3'd4

`endif

// ==== core/vmode_pkg.sv ====
package vmode_pkg;

  typedef enum logic [4:0] {
    port_in_op, port_out_op, port_block_read_op, port_block_write_op,
    mask_set_op, mask_clear_op, soft_int_op, flags_push_op, flags_pop_op,
    trap_return_op, breakpoint_op, overflow_trap_op, bound_check_op,
    load_irq_table_op, load_global_table_op, load_machine_word_op,
    clear_task_switched_op, halt_op, control_reg_move_op, debug_reg_move_op,
    test_reg_move_op, load_task_reg_op, store_task_reg_op, load_local_table_op,
    store_local_table_op, load_access_rights_op, load_seg_limit_op,
    verify_read_op, verify_write_op, plain_op
  } op_t;

  typedef enum logic [1:0] {size_byte, size_word, size_dword, size_rsvd} size_t;

  typedef enum {st_idle, st_ts_read, st_io_read} state_t;

endpackage

// ==== core/tlb_store.sv ====
`timescale 1ns/10ps
`default_nettype none
module tlb_store #(
  parameter int IDX_W = 5,
  parameter int TAG_W = 15,
  parameter int PFN_W = 20
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [TAG_W-1:0] wr_tag,
  input wire logic [PFN_W-1:0] wr_pfn,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic rd_valid,
  output logic [TAG_W-1:0] rd_tag,
  output logic [PFN_W-1:0] rd_pfn
);
  localparam int ENTRIES = 1 << IDX_W;

  logic [TAG_W-1:0] tag_mem [ENTRIES];
  logic [PFN_W-1:0] pfn_mem [ENTRIES];
  logic [ENTRIES-1:0] valid_r;

  // Flush beats a fill in the same cycle so no stale mapping survives
  always_ff @(posedge ref_clk) begin
    if (sys_rst || flush) begin
      valid_r <= '0;
    end else if (wr_en) begin
      valid_r[wr_idx] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      tag_mem[wr_idx] <= wr_tag;
      pfn_mem[wr_idx] <= wr_pfn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_tag <= '0;
      rd_pfn <= '0;
    end else begin
      rd_valid <= valid_r[rd_idx] && !flush;
      rd_tag <= tag_mem[rd_idx];
      rd_pfn <= pfn_mem[rd_idx];
    end
  end
endmodule
`default_nettype wire

// ==== core/vmode_io_protection_check.sv ====
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "vmode_params.svh"
module vmode_io_protection_check #(
  parameter int IDX_W = 5
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_rd_req,
  output logic [31:0] mem_rd_addr,
  input wire logic [7:0] mem_rd_data,
  input wire logic mem_rd_ack,
  output logic check_done,
  output logic check_fault
);
  import vmode_pkg::*;

  localparam int TAG_W = 20 - IDX_W;

  logic [31:0] ctrl_r;
  logic [31:0] page_directory_base_reg;
  logic [31:0] tss_base_r;
  logic [31:0] tss_limit_r;
  logic [15:0] seg_r;
  logic [31:0] ea_r;
  logic [19:0] tlb_vpn_r;
  logic [15:0] bmp_ptr_r;
  logic [15:0] port_r;
  logic [15:0] mask_r;
  logic [15:0] win_r;
  logic [47:0] ts_buf_r;
  logic [2:0] cnt_r;
  logic [2:0] need_r;
  logic [7:0] vec_r;
  logic busy_done_r;
  logic req_r;
  logic [31:0] addr_r;
  logic done_r;
  logic fault_r;
  state_t state_r;

  logic wr_acc;
  logic rd_setup;
  logic prot;
  logic vmode;
  logic paging;
  logic [1:0] cpl_eff;
  logic [1:0] io_privilege_level;
  logic tlb_fill;
  logic ts_load;
  logic flush;
  op_t chk_op;
  size_t chk_size;
  logic [15:0] chk_port;
  logic imm_fault;
  logic [7:0] imm_vec;
  logic io_to_bitmap;
  logic [31:0] lin;
  logic [31:0] phys;
  logic ea_fault;
  logic tlb_valid;
  logic [TAG_W-1:0] tlb_tag;
  logic [19:0] tlb_pfn;
  logic tlb_hit;
  logic [31:0] io_off;
  logic [31:0] ts_addr;
  logic [16:0] last_port;
  logic [15:0] start_mask;
  logic [2:0] start_need;

  // One wait state: a new request is answered on its second access cycle
  assign wr_acc = psel && penable && pready && pwrite;
  assign rd_setup = psel && penable && !pready;

  assign prot = ctrl_r[`CTRL_PROT_BIT];
  assign vmode = ctrl_r[`CTRL_VMODE_BIT];
  assign paging = ctrl_r[`CTRL_PAGING_BIT];
  assign io_privilege_level = ctrl_r[`CTRL_IO_PRIVILEGE_LEVEL_LSB +: 2];
  assign cpl_eff = vmode ? 2'd3 : (prot ? ctrl_r[`CTRL_CPL_LSB +: 2] : 2'd0); // RULE_07

  assign chk_op = op_t'(pwdata[`CHK_OP_LSB +: 5]);
  assign chk_size = size_t'(pwdata[`CHK_SIZE_LSB +: 2]);
  assign chk_port = pwdata[`CHK_PORT_LSB +: 16];

  assign lin = {12'h000, seg_r, 4'h0} + ea_r; // RULE_04
  assign ea_fault = (vmode || !prot) && (ea_r > `EA_MAX); // RULE_05
  assign tlb_hit = tlb_valid && (tlb_tag == lin[31:12+IDX_W]) && (lin[31:20] == 12'h000);
  assign phys = !paging ? lin : (tlb_hit ? {tlb_pfn, lin[11:0]} : 32'h0000_0000); // RULE_06

  assign tlb_fill = wr_acc && (paddr == `TLB_PFN_OFF);
  assign ts_load = (state_r == st_ts_read) && !req_r && (cnt_r == `TS_BYTES);
  assign flush = (wr_acc && (paddr == `PDBR_OFF)) || ts_load; // RULE_01

  tlb_store #(
    .IDX_W(IDX_W),
    .TAG_W(TAG_W),
    .PFN_W(20)
  ) u_tlb (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .flush(flush),
    .wr_en(tlb_fill),
    .wr_idx(tlb_vpn_r[IDX_W-1:0]),
    .wr_tag(tlb_vpn_r[19:IDX_W]),
    .wr_pfn(pwdata[19:0]),
    .rd_idx(lin[12 +: IDX_W]),
    .rd_valid(tlb_valid),
    .rd_tag(tlb_tag),
    .rd_pfn(tlb_pfn)
  );

  // Instruction screening that needs no memory access
  always_comb begin
    imm_fault = 1'b0;
    imm_vec = 8'h00;
    io_to_bitmap = 1'b0;
    case (chk_op)
      load_irq_table_op, load_global_table_op, load_machine_word_op, clear_task_switched_op,
      halt_op, control_reg_move_op, debug_reg_move_op, test_reg_move_op: begin
        imm_fault = (cpl_eff != 2'd0); // RULE_08
        imm_vec = `VEC_GP;
      end
      load_task_reg_op, store_task_reg_op, load_local_table_op, store_local_table_op,
      load_access_rights_op, load_seg_limit_op, verify_read_op, verify_write_op: begin
        imm_fault = !prot || vmode; // RULE_09
        imm_vec = `VEC_UD;
      end
      port_in_op, port_out_op, port_block_read_op, port_block_write_op: begin
        io_to_bitmap = vmode; // RULE_13
        imm_fault = !vmode && prot && (cpl_eff > io_privilege_level); // RULE_10
        imm_vec = `VEC_GP;
      end
      mask_set_op, mask_clear_op: begin
        imm_fault = (prot || vmode) && (cpl_eff > io_privilege_level); // RULE_10 RULE_11
        imm_vec = `VEC_GP;
      end
      soft_int_op, flags_push_op, flags_pop_op, trap_return_op: begin
        imm_fault = vmode && (cpl_eff > io_privilege_level); // RULE_11
        imm_vec = `VEC_GP;
      end
      breakpoint_op, overflow_trap_op, bound_check_op: imm_fault = 1'b0; // RULE_12
      default: imm_fault = 1'b0;
    endcase
  end

  // Bit window for the port: up to four bits that may straddle two bitmap bytes
  always_comb begin
    case (chk_size)
      size_word: start_mask = 16'h0003 << chk_port[2:0]; // RULE_17
      size_dword: start_mask = 16'h000f << chk_port[2:0]; // RULE_17
      default: start_mask = 16'h0001 << chk_port[2:0]; // RULE_16
    endcase
    case (chk_size)
      size_word: last_port = {1'b0, chk_port} + 17'd1;
      size_dword: last_port = {1'b0, chk_port} + 17'd3;
      default: last_port = {1'b0, chk_port};
    endcase
    start_need = (last_port[16:3] != {1'b0, chk_port[15:3]}) ? 3'd2 : 3'd1; // RULE_20
  end

  // Offsets are kept 32 bits wide so a bad pointer cannot wrap below the limit
  assign io_off = {16'h0000, bmp_ptr_r} + {19'h00000, port_r[15:3]} + {29'h0, cnt_r}; // RULE_20 RULE_15
  assign ts_addr = (cnt_r < `PDBR_BYTES) ? tss_base_r + `TSS_PDBR_BYTE + {29'h0, cnt_r}
                 : tss_base_r + `TSS_BMP_PTR_BYTE + {29'h0, cnt_r - `PDBR_BYTES}; // RULE_14

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_r <= `CTRL_RESET;
      tss_base_r <= 32'h0000_0000;
      tss_limit_r <= `TSS_LIMIT_RESET;
      seg_r <= 16'h0000;
      ea_r <= 32'h0000_0000;
      tlb_vpn_r <= 20'h00000;
    end else if (wr_acc) begin
      case (paddr)
        `CTRL_OFF: ctrl_r <= pwdata;
        `TSS_BASE_OFF: tss_base_r <= pwdata;
        `TSS_LIMIT_OFF: tss_limit_r <= pwdata;
        `SEG_OFF: seg_r <= pwdata[15:0];
        `EA_OFF: ea_r <= pwdata;
        `TLB_VPN_OFF: tlb_vpn_r <= pwdata[19:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      page_directory_base_reg <= 32'h0000_0000;
    end else if (ts_load) begin
      page_directory_base_reg <= ts_buf_r[31:0]; // RULE_03
    end else if (wr_acc && (paddr == `PDBR_OFF)) begin
      page_directory_base_reg <= pwdata;
    end
  end

  // Task segment fetches and bitmap walk share one byte-read port
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= st_idle;
      req_r <= 1'b0;
      addr_r <= 32'h0000_0000;
      cnt_r <= 3'd0;
      need_r <= 3'd1;
      port_r <= 16'h0000;
      mask_r <= 16'h0000;
      win_r <= 16'h0000;
      ts_buf_r <= 48'h0;
      bmp_ptr_r <= 16'h0000;
      done_r <= 1'b0;
      fault_r <= 1'b0;
      vec_r <= 8'h00;
      busy_done_r <= 1'b0;
    end else begin
      busy_done_r <= 1'b0;
      case (state_r)
        st_idle: begin
          if (wr_acc && (paddr == `TASK_SWITCH_OFF)) begin
            state_r <= st_ts_read;
            cnt_r <= 3'd0;
          end else if (wr_acc && (paddr == `CHECK_OFF)) begin
            done_r <= 1'b0;
            port_r <= chk_port;
            mask_r <= start_mask;
            need_r <= start_need;
            win_r <= 16'h0000;
            cnt_r <= 3'd0;
            if (io_to_bitmap) begin
              state_r <= st_io_read; // RULE_13
            end else begin
              done_r <= 1'b1;
              busy_done_r <= 1'b1;
              fault_r <= imm_fault;
              vec_r <= imm_fault ? imm_vec : 8'h00;
            end
          end
        end
        st_ts_read: begin
          if (req_r) begin
            if (mem_rd_ack) begin
              req_r <= 1'b0;
              ts_buf_r[cnt_r*8 +: 8] <= mem_rd_data;
              cnt_r <= cnt_r + 3'd1;
            end
          end else if (cnt_r == `TS_BYTES) begin
            bmp_ptr_r <= ts_buf_r[47:32]; // RULE_14
            state_r <= st_idle;
          end else begin
            req_r <= 1'b1;
            addr_r <= ts_addr;
          end
        end
        st_io_read: begin
          if (req_r) begin
            if (mem_rd_ack) begin
              req_r <= 1'b0;
              win_r[cnt_r[0]*8 +: 8] <= mem_rd_data; // RULE_20
              cnt_r <= cnt_r + 3'd1;
            end
          end else if (cnt_r == need_r) begin
            // Any covered bit set refuses the whole access
            fault_r <= |(win_r & mask_r); // RULE_16 RULE_17
            vec_r <= (|(win_r & mask_r)) ? `VEC_GP : 8'h00;
            done_r <= 1'b1;
            busy_done_r <= 1'b1;
            state_r <= st_idle;
          end else if (io_off > tss_limit_r) begin
            // Software's trailing FFH byte sits inside the limit, so it is read and refused by the bit check, not here
            fault_r <= 1'b1; // RULE_18 RULE_19
            vec_r <= `VEC_GP;
            done_r <= 1'b1;
            busy_done_r <= 1'b1;
            state_r <= st_idle;
          end else begin
            req_r <= 1'b1;
            addr_r <= tss_base_r + io_off;
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  assign mem_rd_req = req_r;
  assign mem_rd_addr = addr_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      check_done <= 1'b0;
      check_fault <= 1'b0;
    end else begin
      check_done <= busy_done_r;
      check_fault <= busy_done_r && fault_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (rd_setup) begin
        case (paddr)
          `CTRL_OFF: prdata <= ctrl_r;
          `PDBR_OFF: prdata <= page_directory_base_reg;
          `TSS_BASE_OFF: prdata <= tss_base_r;
          `TSS_LIMIT_OFF: prdata <= tss_limit_r;
          `SEG_OFF: prdata <= {16'h0000, seg_r};
          `EA_OFF: prdata <= ea_r;
          `LIN_OFF: prdata <= lin;
          `PHYS_OFF: prdata <= phys;
          `XLATE_STAT_OFF: prdata <= {16'h0000, ea_fault ? `VEC_GP : 8'h00, 6'h00, tlb_hit, ea_fault};
          `TLB_VPN_OFF: prdata <= {12'h000, tlb_vpn_r};
          `CHECK_STAT_OFF: prdata <= {16'h0000, vec_r, 5'h00, fault_r, done_r, state_r != st_idle};
          `BITMAP_PTR_OFF: prdata <= {16'h0000, bmp_ptr_r};
          `TASK_SWITCH_OFF, `TLB_PFN_OFF, `CHECK_OFF: prdata <= 32'h0000_0000;
          default: pslverr <= 1'b1;
        endcase
      end
      // Writes still answer with the error flag, but read data stays quiet
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/vmode_io_protection_check_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
module vmode_io_protection_check_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic mem_rd_req,
  input wire logic [31:0] mem_rd_addr,
  input wire logic mem_rd_ack,
  input wire logic check_done,
  input wire logic check_fault
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // One wait state, never zero and never more
  a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not one cycle after access start");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_quiet_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read answer");
  a_req_held_addr: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
    else $error("byte request dropped or moved before ack");
  a_req_drops_after: assert property (mem_rd_req && mem_rd_ack |=> !mem_rd_req)
    else $error("byte request not released after ack");
  a_fault_with_done: assert property (check_fault |-> check_done)
    else $error("check_fault outside check_done");
  a_done_one_cycle: assert property (check_done |=> !check_done)
    else $error("check_done longer than one cycle");
endmodule
bind vmode_io_protection_check vmode_io_protection_check_chk u_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .mem_rd_req(mem_rd_req),
  .mem_rd_addr(mem_rd_addr),
  .mem_rd_ack(mem_rd_ack),
  .check_done(check_done),
  .check_fault(check_fault)
);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "vmode_params.svh"
module tb_top;
  import vmode_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, mem_rd_ack = 1'b0;
  logic [7:0] paddr = 8'h00, mem_rd_data = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata, mem_rd_addr;
  logic pready, pslverr, mem_rd_req, check_done, check_fault, er, lastf;
  int err_count = 0, compares = 0, cyc = 0, lat = 0, reqs = 0, wcnt = 0, dn = 0;
  logic [7:0] mem [logic [31:0]];

  always #2 ref_clk = ~ref_clk;

  vmode_io_protection_check dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_rd_ack(mem_rd_ack), .check_done(check_done), .check_fault(check_fault));

  task end_of_test;
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test;
    end
  end

  // Byte memory; data wanders every idle cycle so a stale sample cannot match
  always @(posedge ref_clk) begin
    if (mem_rd_req && !mem_rd_ack && wcnt >= lat) begin
      mem_rd_ack <= 1'b1;
      mem_rd_data <= mem.exists(mem_rd_addr) ? mem[mem_rd_addr] : 8'hff;
      reqs <= reqs + 1;
    end else begin
      mem_rd_ack <= 1'b0;
      mem_rd_data <= ~mem_rd_data;
    end
    wcnt <= (mem_rd_req && !mem_rd_ack) ? wcnt + 1 : 0;
  end

  always @(posedge ref_clk) begin
    if (check_done === 1'b1) begin
      dn <= dn + 1;
      lastf <= check_fault;
    end
  end

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) chk(32'h0, 32'h1);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  task ck(input int op, input logic [1:0] sz, input logic [15:0] pt, input logic [7:0] ev);
    int d0, n;
    d0 = dn;
    n = 0;
    apb(1'b1, `CHECK_OFF, {pt, 9'h000, sz, op[4:0]});
    while (dn == d0 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    if (dn == d0) chk(32'h0, 32'h1);
    chk(lastf, ev != 8'h00);
    apb(1'b0, `CHECK_STAT_OFF, 32'h0);
    chk(rd[15:0], {ev, 5'h00, ev != 8'h00, 2'b10});
  endtask

  // Expected vector from the mode bits: op numbering follows op_t
  function logic [7:0] expv(input int op, input logic [6:0] c);
    logic [1:0] cp;
    cp = c[1] ? 2'd3 : (c[0] ? c[4:3] : 2'd0);
    if (op >= 21 && op <= 28 && (!c[0] || c[1])) return `VEC_UD;
    if (op >= 13 && op <= 20 && cp != 2'd0) return `VEC_GP;
    if (cp > c[6:5] && (c[1] ? (op >= 4 && op <= 9) : (c[0] && op <= 5))) return `VEC_GP;
    return 8'h00;
  endfunction

  task t_reset;
    rdc(`CTRL_OFF, 32'hffffffff, 32'h0);
    rdc(`TSS_LIMIT_OFF, 32'hffffffff, 32'h67);
    apb(1'b1, 8'h3c, 32'h1);
    chk(er, 1'b1);
    apb(1'b0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
  endtask

  task t_addr;
    apb(1'b1, `CTRL_OFF, 32'h3);
    apb(1'b1, `SEG_OFF, 32'h1234);
    apb(1'b1, `EA_OFF, 32'hffff);
    rdc(`LIN_OFF, 32'hffffffff, 32'h2233f);
    rdc(`PHYS_OFF, 32'hffffffff, 32'h2233f);
    rdc(`XLATE_STAT_OFF, 32'hff01, 32'h0);
    apb(1'b1, `EA_OFF, 32'h10000);
    rdc(`XLATE_STAT_OFF, 32'hff01, 32'h0d01);
    apb(1'b1, `CTRL_OFF, 32'h0);
    rdc(`XLATE_STAT_OFF, 32'hff01, 32'h0d01);
    apb(1'b1, `CTRL_OFF, 32'h1);
    rdc(`XLATE_STAT_OFF, 32'hff01, 32'h0);
  endtask

  task t_tlb;
    apb(1'b1, `CTRL_OFF, 32'h7);
    apb(1'b1, `SEG_OFF, 32'hff34);
    apb(1'b1, `EA_OFF, 32'h5);
    apb(1'b1, `TLB_VPN_OFF, 32'hff);
    apb(1'b1, `TLB_PFN_OFF, 32'habcde);
    rdc(`PHYS_OFF, 32'hffffffff, 32'habcde345);
    rdc(`XLATE_STAT_OFF, 32'h2, 32'h2);
    apb(1'b1, `PDBR_OFF, 32'h5000);
    rdc(`PHYS_OFF, 32'hffffffff, 32'h0);
    rdc(`XLATE_STAT_OFF, 32'h2, 32'h0);
    apb(1'b1, `TLB_PFN_OFF, 32'habcde);
    rdc(`PHYS_OFF, 32'hffffffff, 32'habcde345);
  endtask

  task t_ts;
    int n, r0;
    mem[32'h101c] = 8'h78;
    mem[32'h101d] = 8'h56;
    mem[32'h101e] = 8'h34;
    mem[32'h101f] = 8'h12;
    mem[32'h1066] = 8'h80;
    mem[32'h1067] = 8'h00;
    lat = 2;
    r0 = reqs;
    n = 0;
    apb(1'b1, `TSS_BASE_OFF, 32'h1000);
    apb(1'b1, `TASK_SWITCH_OFF, 32'h0);
    do apb(1'b0, `CHECK_STAT_OFF, 32'h0); while (rd[0] !== 1'b0 && ++n < 40);
    chk(rd[0], 1'b0);
    chk(reqs - r0, 32'd6);
    rdc(`PDBR_OFF, 32'hffffffff, 32'h12345678);
    rdc(`BITMAP_PTR_OFF, 32'hffff, 32'h80);
    rdc(`PHYS_OFF, 32'hffffffff, 32'h0);
  endtask

  task t_ops;
    logic [6:0] m [6];
    m = '{7'h00, 7'h01, 7'h19, 7'h49, 7'h03, 7'h63};
    foreach (m[i]) begin
      apb(1'b1, `CTRL_OFF, {25'h0, m[i]});
      // Port ops in legacy mode go to the bitmap scenario instead
      for (int op = 0; op < 30; op++)
        if (!(m[i][1] && op < 4)) ck(op, 2'd0, 16'h0, expv(op, m[i]));
    end
  endtask

  task t_bmp;
    int r0;
    mem[32'h1080] = 8'h00;
    mem[32'h1081] = 8'h80;
    mem[32'h1082] = 8'h00;
    mem[32'h1083] = 8'h01;
    mem[32'h1084] = 8'hff;
    apb(1'b1, `CTRL_OFF, 32'h3);
    apb(1'b1, `TSS_LIMIT_OFF, 32'h84);
    lat = 0;
    ck(0, 2'd0, 16'h05, 8'h00);
    ck(1, 2'd0, 16'h0f, `VEC_GP);
    ck(2, 2'd1, 16'h0d, 8'h00);
    ck(3, 2'd1, 16'h0e, `VEC_GP);
    ck(0, 2'd0, 16'h20, `VEC_GP);
    lat = 3;
    ck(0, 2'd2, 16'h10, 8'h00);
    ck(1, 2'd2, 16'h16, `VEC_GP);
    apb(1'b1, `TSS_LIMIT_OFF, 32'h82);
    ck(0, 2'd0, 16'h17, 8'h00);
    r0 = reqs;
    ck(0, 2'd0, 16'h18, `VEC_GP);
    chk(reqs - r0, 32'd0);
    apb(1'b1, `TSS_LIMIT_OFF, 32'h7f);
    ck(1, 2'd0, 16'h00, `VEC_GP);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_addr;
    t_tlb;
    t_ts;
    t_ops;
    t_bmp;
    end_of_test;
  end
endmodule
`default_nettype wire
